// ### rtl/operating_watchdog.v
// Operating watchdog top: AHB-Lite register slave, mode gating, reset pulse.
// Assumes hclk drives logic; crystal rate given as one-cycle xtal_tick enable.
`timescale 1ns/100ps
`include "watchdog_defs.vh"

module operating_watchdog #(
	parameter POR_CYCLES = `WD_POR_CYCLES,
	parameter RST_CYCLES = `WD_RST_CYCLES
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire xtal_tick,
	input wire internal_reset,
	input wire vector_fetch,
	input wire stop_exec,
	input wire wait_mode,
	input wire monitor_mode,
	input wire break_active,
	input wire irq_high_voltage,
	input wire rst_high_voltage,
	output reg ext_bus_write_ff,
	output reg [7:0] ext_bus_data_ff,
	output reg wd_reset_ff,
	output wire rst_pin_out_n,
	output wire rst_pin_oe,
	output reg por_done_ff
);

	reg [`WD_CTRL_WIDTH-1:0] ctrl_ff;
	reg [15:0] vector_ff;
	reg wdrst_flag_ff;
	reg stopped_ff;
	reg [5:0] rst_cnt_ff;
	reg [12:0] por_cnt_ff;
	reg wr_pend_ff;
	reg [31:0] wr_addr_ff;
	reg [31:0] nxt_rdata;
	wire take;
	wire wr_now;
	wire svc_wr;
	wire suppress;
	wire run;
	wire overflow;
	wire clr_all;
	wire clr_pre;
	wire stop_take;

	////////////////////////////////////////////////////////////////////////
	// Bus handshake: single-cycle, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign take = hsel && hready && htrans[1];
	assign wr_now = wr_pend_ff;
	assign svc_wr = wr_pend_ff && (wr_addr_ff[31:2] == `WD_SERVICE_WORD >> 2);

	// Address phase capture; reads need none, their data is registered here
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 32'h00000000;
		end else begin
			wr_pend_ff <= take && hwrite;
			if (take) begin
				wr_addr_ff <= haddr;
			end
		end
	end

	// Read mux; service address yields vector low byte, never watchdog state
	always @* begin
		nxt_rdata = 32'h00000000;
		if (take && !hwrite) begin
			case (haddr[31:2])
				`WD_SERVICE_WORD >> 2: nxt_rdata = {24'h000000, vector_ff[7:0]};
				`WD_CTRL_ADDR >> 2: nxt_rdata = {28'h0000000, ctrl_ff};
				`WD_STATUS_ADDR >> 2: nxt_rdata = {28'h0000000, !rst_pin_out_n, stopped_ff,
					por_done_ff, wdrst_flag_ff};
				`WD_VECTOR_ADDR >> 2: nxt_rdata = {16'h0000, vector_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end
	end

	// Read data register, presented in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and vector registers written in data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `WD_CTRL_RESET;
			vector_ff <= `WD_VECTOR_RESET;
		end else if (wr_now) begin
			if (wr_addr_ff[31:2] == `WD_CTRL_ADDR >> 2) begin
				ctrl_ff <= hwdata[`WD_CTRL_WIDTH-1:0];
			end
			if (wr_addr_ff[31:2] == `WD_VECTOR_ADDR >> 2) begin
				vector_ff <= hwdata[15:0];
			end
		end
	end

	// Service write mirrored onto external bus in expanded mode
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_bus_write_ff <= 1'b0;
			ext_bus_data_ff <= 8'h00;
		end else begin
			ext_bus_write_ff <= svc_wr && ctrl_ff[`WD_CTRL_EXPANDED];
			if (svc_wr) begin
				ext_bus_data_ff <= hwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stop mode: only honoured when halt enable is set; held until wake
	assign stop_take = stop_exec && ctrl_ff[`WD_CTRL_HALT_EN];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stopped_ff <= 1'b0;
		end else if (stop_take) begin
			stopped_ff <= 1'b1;
		end else if (!stop_exec) begin
			stopped_ff <= 1'b0;
		end
	end

	// Test-voltage suppression in monitor and break states
	assign suppress = (monitor_mode && (irq_high_voltage || rst_high_voltage)) ||
		(break_active && rst_high_voltage);
	// Wait mode deliberately absent: the watchdog keeps running there
	assign run = !ctrl_ff[`WD_CTRL_DISABLE] && !suppress && !stopped_ff && !stop_take;
	assign clr_all = internal_reset || !por_done_ff;
	assign clr_pre = vector_fetch || stop_take;

	watchdog_core #(
		.PRE_BITS(`WD_PRE_BITS),
		.CNT_BITS(`WD_CNT_BITS)
	) u_core (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(xtal_tick),
		.run(run),
		.long_sel(ctrl_ff[`WD_CTRL_RATE]),
		.clr_all(clr_all),
		.clr_pre(clr_pre),
		.service(svc_wr),
		.overflow_ff(overflow),
		.count()
	);

	////////////////////////////////////////////////////////////////////////
	// Power-on delay counted in crystal ticks
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			por_cnt_ff <= 13'h0000;
			por_done_ff <= 1'b0;
		end else if (!por_done_ff && xtal_tick) begin
			if (por_cnt_ff == POR_CYCLES - 1) begin
				por_done_ff <= 1'b1;
			end else begin
				por_cnt_ff <= por_cnt_ff + 13'h0001;
			end
		end
	end

	// Reset pulse: pin low for a fixed count of crystal ticks
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_cnt_ff <= 6'h00;
			wd_reset_ff <= 1'b0;
		end else if (overflow && !ctrl_ff[`WD_CTRL_DISABLE]) begin
			rst_cnt_ff <= RST_CYCLES[5:0];
			wd_reset_ff <= 1'b1;
		end else if (rst_cnt_ff != 6'h00) begin
			if (xtal_tick) begin
				rst_cnt_ff <= rst_cnt_ff - 6'h01;
				// Flag drops with the pin drive so both end on one edge
				if (rst_cnt_ff == 6'h01) begin
					wd_reset_ff <= 1'b0;
				end
			end
		end else begin
			wd_reset_ff <= 1'b0;
		end
	end
	// Open-drain: drive low only while the pulse runs
	assign rst_pin_out_n = (rst_cnt_ff == 6'h00);
	assign rst_pin_oe = (rst_cnt_ff != 6'h00);

	// Sticky watchdog-reset flag; a set wins over a same-cycle clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdrst_flag_ff <= 1'b0;
		end else if (overflow) begin
			wdrst_flag_ff <= 1'b1;
		end else if (wr_now && wr_addr_ff[31:2] == `WD_STATUS_ADDR >> 2 && hwdata[`WD_STAT_WDRST]) begin
			wdrst_flag_ff <= 1'b0;
		end
	end

endmodule // operating_watchdog

// ### rtl/watchdog_defs.vh
// Constants for the operating watchdog: register offsets, counts, reset values.
// Assumes inclusion by bare name from the watchdog design files only.
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// Bus byte addresses: service register index, its word address, chosen others
`define WD_SERVICE_IDX 32'h0000ffff
`define WD_SERVICE_WORD 32'h0003fffc
`define WD_CTRL_ADDR 32'h00000000
`define WD_STATUS_ADDR 32'h00000004
`define WD_VECTOR_ADDR 32'h00000008

// Control register fields
`define WD_CTRL_RATE 0
`define WD_CTRL_DISABLE 1
`define WD_CTRL_HALT_EN 2
`define WD_CTRL_EXPANDED 3
`define WD_CTRL_WIDTH 4
`define WD_CTRL_RESET 4'h0

// Status register fields
`define WD_STAT_WDRST 0
`define WD_STAT_POR_DONE 1
`define WD_STAT_STOPPED 2
`define WD_STAT_RSTPIN 3

// Counter geometry and overflow taps
`define WD_PRE_BITS 12
`define WD_CNT_BITS 6
// Counter and prescaler form one 18-bit chain; overflow on 2^13-2^4 or 2^18-2^4
`define WD_PRE_WRAP 12'hfff
`define WD_OVF_PRE 12'hfef
`define WD_SHORT_LAST 6'h01
`define WD_LONG_LAST 6'h3f
`define WD_RST_CYCLES 32
`define WD_POR_CYCLES 4096
`define WD_VECTOR_RESET 16'h0000

`endif

// ### rtl/watchdog_core.v
// Watchdog prescaler and counter with overflow detection.
// Assumes a one-cycle crystal tick enable and synchronous clear strobes.
`timescale 1ns/100ps
`include "watchdog_defs.vh"

module watchdog_core #(
	parameter PRE_BITS = `WD_PRE_BITS,
	parameter CNT_BITS = `WD_CNT_BITS
) (
	input wire hclk,
	input wire hresetn,
	input wire tick,
	input wire run,
	input wire long_sel,
	input wire clr_all,
	input wire clr_pre,
	input wire service,
	output reg overflow_ff,
	output wire [CNT_BITS-1:0] count
);

	reg [PRE_BITS-1:0] pre_ff;
	reg [CNT_BITS-1:0] cnt_ff;
	reg [PRE_BITS-1:0] nxt_pre;
	reg [CNT_BITS-1:0] nxt_cnt;
	reg nxt_overflow;
	wire carry;
	wire last;

	assign count = cnt_ff;
	// Counter steps each time the prescaler wraps
	assign carry = (pre_ff == `WD_PRE_WRAP);
	// Last tick of the selected count; short also catches a counter left high by long
	assign last = (pre_ff == `WD_OVF_PRE) &&
		(long_sel ? (cnt_ff == `WD_LONG_LAST) : (cnt_ff >= `WD_SHORT_LAST));

	////////////////////////////////////////////////////////////////////////
	// Next-state: clears outrank counting
	always @* begin
		nxt_pre = pre_ff;
		nxt_cnt = cnt_ff;
		nxt_overflow = 1'b0;
		if (clr_all) begin
			nxt_pre = {PRE_BITS{1'b0}};
			nxt_cnt = {CNT_BITS{1'b0}};
		end else if (clr_pre) begin
			nxt_pre = {PRE_BITS{1'b0}};
		end else if (service) begin
			nxt_cnt = {CNT_BITS{1'b0}};
			nxt_pre = pre_ff & {{(PRE_BITS-4){1'b0}}, 4'hf};
		end else if (run && tick) begin
			nxt_pre = pre_ff + {{(PRE_BITS-1){1'b0}}, 1'b1};
			if (last) begin
				nxt_overflow = 1'b1;
				nxt_pre = {PRE_BITS{1'b0}};
				nxt_cnt = {CNT_BITS{1'b0}};
			end else if (carry) begin
				nxt_cnt = cnt_ff + {{(CNT_BITS-1){1'b0}}, 1'b1};
			end
		end
	end

	// State registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_ff <= {PRE_BITS{1'b0}};
			cnt_ff <= {CNT_BITS{1'b0}};
			overflow_ff <= 1'b0;
		end else begin
			pre_ff <= nxt_pre;
			cnt_ff <= nxt_cnt;
			overflow_ff <= nxt_overflow;
		end
	end

endmodule // watchdog_core

// ### bench/watchdog_monitor.sv
// Port checks for the operating watchdog.
// Assumes a bind onto operating_watchdog, parameters handed on.
`timescale 1ns/100ps
module watchdog_monitor #(
	parameter POR_CYCLES = 4096,
	parameter RST_CYCLES = 32
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire xtal_tick,
	input wire internal_reset,
	input wire monitor_mode,
	input wire rst_high_voltage,
	input wire ext_bus_write_ff,
	input wire [7:0] ext_bus_data_ff,
	input wire wd_reset_ff,
	input wire rst_pin_out_n,
	input wire rst_pin_oe,
	input wire por_done_ff
);
////////////////
// Service data phase flag; ticks seen while the pulse stands
reg svc_dp_ff;
reg [7:0] pulse_cnt_ff;
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		svc_dp_ff <= 1'b0;
		pulse_cnt_ff <= 8'h00;
	end else begin
		svc_dp_ff <= hsel & hready & htrans[1] & hwrite & (haddr[31:2] == 30'h0000ffff);
		pulse_cnt_ff <= wd_reset_ff ? pulse_cnt_ff + {7'h00, xtal_tick} : 8'h00;
	end
end
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
////////////////
// Pin, pulse length, mirror, read data, gating
property p_pin; rst_pin_oe == wd_reset_ff && rst_pin_out_n == !wd_reset_ff; endproperty
a_pin: assert property (p_pin) else $error("reset pin off pulse");
property p_plong; wd_reset_ff |-> pulse_cnt_ff <= RST_CYCLES; endproperty
a_plong: assert property (p_plong) else $error("pulse too long");
property p_pshort; $fell(wd_reset_ff) |-> pulse_cnt_ff >= RST_CYCLES - 1; endproperty
a_pshort: assert property (p_pshort) else $error("pulse too short");
property p_mirror;
	ext_bus_write_ff |-> $past(svc_dp_ff) && ext_bus_data_ff == $past(hwdata[7:0]);
endproperty
a_mirror: assert property (p_mirror) else $error("bad bus mirror");
property p_rdata; !$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite); endproperty
a_rdata: assert property (p_rdata) else $error("read data moved");
property p_por; !por_done_ff |-> !wd_reset_ff; endproperty
a_por: assert property (p_por) else $error("reset before power-on");
property p_mon; (monitor_mode && rst_high_voltage)[*4] |-> !$rose(wd_reset_ff); endproperty
a_mon: assert property (p_mon) else $error("reset in monitor");
property p_irst; internal_reset[*4] |-> !$rose(wd_reset_ff); endproperty
a_irst: assert property (p_irst) else $error("reset under clear");
endmodule // watchdog_monitor
bind operating_watchdog watchdog_monitor #(.POR_CYCLES(POR_CYCLES), .RST_CYCLES(RST_CYCLES))
	watchdog_monitor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.xtal_tick(xtal_tick), .internal_reset(internal_reset), .monitor_mode(monitor_mode),
	.rst_high_voltage(rst_high_voltage), .ext_bus_write_ff(ext_bus_write_ff),
	.ext_bus_data_ff(ext_bus_data_ff), .wd_reset_ff(wd_reset_ff),
	.rst_pin_out_n(rst_pin_out_n), .rst_pin_oe(rst_pin_oe), .por_done_ff(por_done_ff));

// ### bench/operating_watchdog_tb.sv
// Self-checking bench for the operating watchdog.
// Assumes the checker binds itself; crystal tick every hclk.
`timescale 1ns/100ps
module operating_watchdog_tb;
localparam integer SHORT_TICKS = (1 << 13) - (1 << 4);
reg hclk = 1'b0;
reg hresetn = 1'b0;
reg hsel = 1'b0;
reg [31:0] haddr = 32'h0;
reg [1:0] htrans = 2'h0;
reg hwrite = 1'b0;
reg [2:0] hsize = 3'h2;
reg [31:0] hwdata = 32'h0;
reg xtal_tick = 1'b1;
reg [7:0] lvl = 8'h00; // Mode and clear levels
reg [31:0] rd;
reg [31:0] v;
wire hready;
wire hreadyout;
wire hresp;
wire [31:0] hrdata;
wire ext_bus_write_ff;
wire [7:0] ext_bus_data_ff;
wire wd_reset_ff;
wire rst_pin_out_n;
wire rst_pin_oe;
wire por_done_ff;
integer err_count = 0;
integer checks_done = 0;
integer seed = 65411;
integer n;
integer i;
assign hready = hreadyout;
always #4 hclk = ~hclk;
// Short power-on count keeps the run brief
operating_watchdog #(.POR_CYCLES(8), .RST_CYCLES(32)) operating_watchdog_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xtal_tick(xtal_tick),
	.internal_reset(lvl[0]), .vector_fetch(lvl[1]), .stop_exec(lvl[2]),
	.wait_mode(lvl[3]), .monitor_mode(lvl[4]), .break_active(lvl[5]),
	.irq_high_voltage(lvl[6]), .rst_high_voltage(lvl[7]),
	.ext_bus_write_ff(ext_bus_write_ff), .ext_bus_data_ff(ext_bus_data_ff),
	.wd_reset_ff(wd_reset_ff), .rst_pin_out_n(rst_pin_out_n), .rst_pin_oe(rst_pin_oe),
	.por_done_ff(por_done_ff));
////////////////
// Gated cases: control bits over level inputs
function [11:0] case_of(input integer k);
begin
	case (k)
	0: case_of = 12'h200;
	1: case_of = 12'h050;
	2: case_of = 12'h090;
	3: case_of = 12'h0a0;
	4: case_of = 12'h404;
	5: case_of = 12'h001;
	6: case_of = 12'h002;
	default: case_of = 12'h100;
	endcase
end
endfunction
task wrap_up;
begin
	if (err_count == 0 && checks_done > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
end
endtask
task chk(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
begin
	checks_done = checks_done + 1;
	if (got !== exp) begin
		err_count = err_count + 1;
		$display("mismatch %0s expected %h seen %h", what, exp, got);
	end
end
endtask
// Single transfer; no wait-state count assumed
task bus(input w, input [31:0] a, input [31:0] d, output [31:0] r);
begin
	@(posedge hclk);
	hsel <= 1'b1;
	haddr <= a;
	htrans <= 2'h2;
	hwrite <= w;
	@(posedge hclk);
	while (hready !== 1'b1) @(posedge hclk);
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= d;
	@(posedge hclk);
	while (hready !== 1'b1) @(posedge hclk);
	r = hrdata;
end
endtask
task wr(input [31:0] a, input [31:0] d);
	bus(1'b1, a, d, rd);
endtask
// Expects no reset pulse over cyc cycles
task quiet(input integer cyc);
begin
	for (n = 0; n < cyc; n = n + 1) begin
		@(posedge hclk);
		if (wd_reset_ff !== 1'b0) n = cyc + 1;
	end
	chk("quiet", cyc, n);
end
endtask
////////////////
initial begin
	repeat (96000) @(posedge hclk);
	err_count = err_count + 1;
	wrap_up;
end
initial begin
	repeat (5) @(posedge hclk);
	hresetn <= 1'b1;
	repeat (2) @(posedge hclk);
	chk("por0", 32'h0, {31'h0, por_done_ff});
	repeat (18) @(posedge hclk);
	bus(1'b0, 32'h0, 32'h0, rd);
	chk("ctrl", 32'h0, rd);
	chk("hresp", 32'h0, {31'h0, hresp});
	bus(1'b0, 32'h4, 32'h0, rd);
	chk("status", 32'h2, rd);
	bus(1'b0, 32'h100, 32'h0, rd);
	chk("unmap", 32'h0, rd);
	v = $random(seed);
	wr(32'h8, v);
	bus(1'b0, 32'h3fffc, 32'h0, rd);
	chk("svc_rd", {24'h0, v[7:0]}, rd);
	for (i = 0; i < 8; i = i + 1) begin
		v = case_of(i);
		wr(32'h0, {28'h0, v[11:8]});
		wr(32'h3fffc, $random(seed));
		lvl <= v[7:0];
		wr(32'h3fffc, $random(seed));
		quiet(8300);
		bus(1'b0, 32'h4, 32'h0, rd);
		chk("stopped", {29'h0, i == 4, 2'h2}, rd);
		lvl <= 8'h00;
	end
	// Expanded, short rate, wait mode on: serviced, then left
	wr(32'h0, 32'h8);
	lvl <= 8'h08;
	repeat (3) begin
		v = $random(seed);
		wr(32'h3fffc, v);
		#1;
		chk("ext_wr", 32'h1, {31'h0, ext_bus_write_ff});
		chk("ext_dat", {24'h0, v[7:0]}, {24'h0, ext_bus_data_ff});
		quiet(5000);
	end
	wr(32'h3fffc, v);
	for (n = 0; n < 12000 && wd_reset_ff !== 1'b1; n = n + 1) @(posedge hclk);
	// Low four prescaler stages survive a service, so up to 15 ticks early
	chk("timeout", 32'h1, {31'h0, n >= SHORT_TICKS - 16 && n <= SHORT_TICKS + 2});
	#1;
	chk("pin", 32'h2, {30'h0, rst_pin_oe, rst_pin_out_n});
	for (n = 0; n < 200 && wd_reset_ff !== 1'b0; n = n + 1) @(posedge hclk);
	chk("pulse", 32'd32, n);
	bus(1'b0, 32'h4, 32'h0, rd);
	chk("flag", 32'h3, {30'h0, rd[1:0]});
	wr(32'h4, 32'h1);
	bus(1'b0, 32'h4, 32'h0, rd);
	chk("flag_clr", 32'h0, {31'h0, rd[0]});
	wrap_up;
end
endmodule // operating_watchdog_tb
